//--- common/qmfr_pkg.sv
// qmfr_pkg: constants for the mapped flash read sequencer.
// assumes a 40 MHz system clock and Avalon-MM byte addressing.
package qmfr_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int AW = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_GAP = 8'h04;
	localparam logic [7:0] OFS_REMAP = 8'h08;
	localparam logic [7:0] OFS_CFG = 8'h0c;
	localparam logic [7:0] OFS_MODE = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [11:0] REMAP_RST = 12'h000;
	localparam logic [3:0] GAP_RST = 4'h0;
	localparam logic ROLE_RST = 1'b0;
	localparam int F_EN = 0;
	localparam int F_AW = 1;
	localparam int F_ADDRL = 2;
	localparam int F_DUML = 4;
	localparam int F_DATL = 6;
	localparam int F_DLEN = 8;
	localparam int F_DDRV = 12;
	localparam int F_KEEP = 8;
	localparam int F_EXIT = 0;
	localparam int F_REMAP = 4;
	localparam int REMAP_LSB = 20;
	localparam logic [1:0] LANE_SINGLE = 2'h0;
	localparam logic [1:0] LANE_DUAL = 2'h1;
	localparam logic [1:0] LANE_QUAD = 2'h2;
	localparam logic [5:0] ADDR24 = 6'h18;
	localparam logic [5:0] ADDR32 = 6'h20;
	localparam logic [5:0] WORD_BITS = 6'h20;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam int SCK_HALF_DEF = 4;
	localparam int FIFO_DEPTH = 8;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_GAP = 3'b001,
		ST_ADDR = 3'b010,
		ST_DUMMY = 3'b011,
		ST_DATA = 3'b100,
		ST_PUSH = 3'b101,
		ST_HOLD = 3'b110
	} qmfr_state_e;
endpackage : qmfr_pkg

//--- design/qmfr_seq.sv
// qmfr_seq: mapped execute-in-place read sequencer for a quad serial flash,
// with its read-data FIFO. assumes an Avalon-MM master and a flash in XIP mode.
// Contract
// - data lane width from data_lane_mode
// - quad uses four lines, else lines 1:0
// - dummy lane width from dummy_lane_mode
// - address lane width from addr_lane_mode
// - addr_width_sel picks four or three bytes
// - mapped mode only while mapped_read_en set
// - enable fall sends address plus dummy cycle
// - that address is all ones, sized
// - that dummy carries session_exit_byte, configured lengths
// - enable ignored while controller_role is zero
// - session_keep_byte in bits 15:8, used
// - session_exit_byte in bits 7:0
// - mode byte shifted out LSB first
// - dummy length is field plus one
// - drive lines field plus one dummy clocks
// - non-sequential read idles select gap plus one
// - flash address is remap base plus offset
module qmfr_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = qmfr_pkg::FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	import qmfr_pkg::*;
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wptr;
	logic [PW-1:0] rptr;
	logic [PW:0] count;
	logic push;
	logic pop;
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	assign o_ready = (count != FULL);
	assign o_valid = (count != '0);
	assign o_data = mem[rptr];
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wptr <= (wptr == LAST) ? '0 : wptr + 1'b1;
			end
			if (pop) begin
				rptr <= (rptr == LAST) ? '0 : rptr + 1'b1;
			end
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wptr] <= i_data;
		end
	end
endmodule : qmfr_fifo

module qmfr_seq #(
	parameter int SCK_HALF = qmfr_pkg::SCK_HALF_DEF,
	parameter int DEPTH = qmfr_pkg::FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [qmfr_pkg::AW-1:0] i_avm_address,
	input wire logic i_avm_read,
	input wire logic i_avm_write,
	input wire logic [31:0] i_avm_writedata,
	input wire logic [3:0] i_avm_byteenable,
	output logic [31:0] o_avm_readdata,
	output logic o_avm_waitrequest,
	input wire logic i_rd_valid,
	input wire logic [31:0] i_rd_addr,
	output logic o_rd_ready,
	output logic o_rdata_valid,
	output logic [31:0] o_rdata,
	input wire logic i_rdata_ready,
	output logic o_flash_select_n,
	output logic o_sck,
	output logic [3:0] o_sdl_out,
	output logic [3:0] o_sdl_oe_n,
	input wire logic [3:0] i_sdl_in
);
	import qmfr_pkg::*;
	localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);

	logic controller_role;
	logic [3:0] select_idle_gap;
	logic [11:0] remap_base;
	logic [15:0] flash_map_read_config;
	logic [15:0] xip_mode_bytes;
	qmfr_state_e state;
	logic [5:0] cnt;
	logic [4:0] drv;
	logic [3:0] gcnt;
	logic [7:0] div;
	logic [31:0] sh;
	logic [31:0] pend_fa;
	logic [31:0] next_fa;
	logic exiting;
	logic sess_open;
	logic exit_pend;
	logic eff_q;
	logic [3:0] sdl_s1;
	logic [3:0] sdl_s2;
	logic fifo_in_rdy;
	logic push;

	// bus access and field decode
	logic wr_go;
	logic rd_go;
	logic eff_en;
	logic [1:0] addr_lg;
	logic [1:0] dum_lg;
	logic [1:0] dat_lg;
	logic [5:0] addr_clks;
	logic [5:0] dat_clks;
	logic [7:0] mode_cur;
	logic [31:0] fa;
	logic acc;
	logic active;
	logic tick;
	logic rise;
	logic fall;
	logic [3:0] fill;

	function automatic logic [1:0] lg_of(input logic [1:0] code);
		case (code)
			LANE_QUAD: lg_of = 2'd2;
			LANE_DUAL: lg_of = 2'd1;
			default: lg_of = 2'd0;
		endcase
	endfunction : lg_of

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		merge = old;
		if (be[0]) begin
			merge[7:0] = wd[7:0];
		end
		if (be[1]) begin
			merge[15:8] = wd[15:8];
		end
	endfunction : merge

	function automatic logic [7:0] rev8(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			rev8[i] = b[7-i];
		end
	endfunction : rev8

	assign wr_go = i_avm_write && !o_avm_waitrequest;
	assign rd_go = i_avm_read && o_avm_waitrequest;
	assign eff_en = flash_map_read_config[F_EN] && controller_role;
	assign addr_lg = lg_of(flash_map_read_config[F_ADDRL +: 2]);
	assign dum_lg = lg_of(flash_map_read_config[F_DUML +: 2]);
	assign dat_lg = lg_of(flash_map_read_config[F_DATL +: 2]);
	assign addr_clks = (flash_map_read_config[F_AW] ? ADDR32 : ADDR24) >> addr_lg;
	assign dat_clks = WORD_BITS >> dat_lg;
	assign mode_cur = exiting ? xip_mode_bytes[F_EXIT +: 8] : xip_mode_bytes[F_KEEP +: 8];
	assign fa = {remap_base, REMAP_LSB'(0)} + i_rd_addr;
	assign acc = i_rd_valid && o_rd_ready;
	assign active = (state == ST_ADDR) || (state == ST_DUMMY) || (state == ST_DATA);
	assign tick = active && (div == HALF_M1);
	assign rise = tick && !o_sck;
	assign fall = tick && o_sck;
	assign fill = {4{exiting}};
	assign push = (state == ST_PUSH);

	// register file
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			controller_role <= ROLE_RST;
			select_idle_gap <= GAP_RST;
			remap_base <= REMAP_RST;
			flash_map_read_config <= CFG_RST;
			xip_mode_bytes <= MODE_RST;
		end else if (wr_go) begin
			case (i_avm_address)
				OFS_CTRL: begin
					if (i_avm_byteenable[0]) begin
						controller_role <= i_avm_writedata[0];
					end
				end
				OFS_GAP: begin
					if (i_avm_byteenable[0]) begin
						select_idle_gap <= i_avm_writedata[3:0];
					end
				end
				OFS_REMAP: remap_base <= 12'(merge({remap_base, 4'h0}, i_avm_writedata,
					i_avm_byteenable) >> F_REMAP);
				OFS_CFG: flash_map_read_config <= merge(flash_map_read_config,
					i_avm_writedata, i_avm_byteenable);
				OFS_MODE: xip_mode_bytes <= merge(xip_mode_bytes, i_avm_writedata,
					i_avm_byteenable);
				default: begin
				end
			endcase
		end
	end

	// one wait cycle per access, read data set up with it
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avm_waitrequest <= 1'b1;
			o_avm_readdata <= '0;
		end else begin
			o_avm_waitrequest <= !((i_avm_read || i_avm_write) && o_avm_waitrequest);
			if (rd_go) begin
				case (i_avm_address)
					OFS_CTRL: o_avm_readdata <= {31'h0, controller_role};
					OFS_GAP: o_avm_readdata <= {28'h0, select_idle_gap};
					OFS_REMAP: o_avm_readdata <= {16'h0, remap_base, 4'h0};
					OFS_CFG: o_avm_readdata <= {16'h0, flash_map_read_config};
					OFS_MODE: o_avm_readdata <= {16'h0, xip_mode_bytes};
					OFS_STAT: o_avm_readdata <= {28'h0, eff_en, exit_pend, sess_open,
						state != ST_IDLE};
					default: o_avm_readdata <= '0;
				endcase
			end
		end
	end

	// pin input synchroniser
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sdl_s1 <= '0;
			sdl_s2 <= '0;
		end else begin
			sdl_s1 <= i_sdl_in;
			sdl_s2 <= sdl_s1;
		end
	end

	// enable fall detect; a new fall beats the clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			eff_q <= 1'b0;
			exit_pend <= 1'b0;
		end else begin
			eff_q <= eff_en;
			if (eff_q && !eff_en) begin
				exit_pend <= 1'b1;
			end else if ((state == ST_IDLE || state == ST_HOLD) && exit_pend) begin
				exit_pend <= 1'b0;
			end
		end
	end

	// serial clock divider
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div <= '0;
			o_sck <= 1'b0;
		end else if (!active) begin
			div <= '0;
			o_sck <= 1'b0;
		end else if (tick) begin
			div <= '0;
			o_sck <= !o_sck;
		end else begin
			div <= div + 8'd1;
		end
	end

	// sequencer
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			cnt <= '0;
			drv <= '0;
			gcnt <= '0;
			sh <= '0;
			pend_fa <= '0;
			next_fa <= '0;
			exiting <= 1'b0;
			sess_open <= 1'b0;
			o_flash_select_n <= 1'b1;
		end else begin
			case (state)
				ST_IDLE, ST_HOLD: begin
					if (exit_pend) begin
						exiting <= 1'b1;
						gcnt <= select_idle_gap;
						o_flash_select_n <= 1'b1;
						state <= ST_GAP;
					end else if (acc && state == ST_HOLD && sess_open && fa == next_fa) begin
						cnt <= dat_clks;
						state <= ST_DATA;
					end else if (acc) begin
						pend_fa <= fa;
						gcnt <= select_idle_gap;
						o_flash_select_n <= 1'b1;
						state <= ST_GAP;
					end
				end
				ST_GAP: begin
					if (gcnt == '0) begin
						o_flash_select_n <= 1'b0;
						cnt <= addr_clks;
						if (exiting) begin
							sh <= '1;
						end else if (flash_map_read_config[F_AW]) begin
							sh <= pend_fa;
						end else begin
							sh <= {pend_fa[23:0], 8'h00};
						end
						state <= ST_ADDR;
					end else begin
						gcnt <= gcnt - 4'd1;
					end
				end
				ST_ADDR: begin
					if (fall) begin
						case (addr_lg)
							2'd2: sh <= {sh[27:0], fill};
							2'd1: sh <= {sh[29:0], fill[1:0]};
							default: sh <= {sh[30:0], fill[0]};
						endcase
						cnt <= cnt - 6'd1;
						if (cnt == 6'd1) begin
							sh <= {rev8(mode_cur), 24'h0};
							cnt <= {2'b00, flash_map_read_config[F_DLEN +: 4]} + 6'd1;
							drv <= {1'b0, flash_map_read_config[F_DDRV +: 4]} + 5'd1;
							state <= ST_DUMMY;
						end
					end
				end
				ST_DUMMY: begin
					if (fall) begin
						case (dum_lg)
							2'd2: sh <= {sh[27:0], 4'h0};
							2'd1: sh <= {sh[29:0], 2'h0};
							default: sh <= {sh[30:0], 1'b0};
						endcase
						cnt <= cnt - 6'd1;
						if (drv != '0) begin
							drv <= drv - 5'd1;
						end
						if (cnt == 6'd1) begin
							if (exiting) begin
								exiting <= 1'b0;
								sess_open <= 1'b0;
								o_flash_select_n <= 1'b1;
								state <= ST_IDLE;
							end else begin
								cnt <= dat_clks;
								state <= ST_DATA;
							end
						end
					end
				end
				ST_DATA: begin
					if (rise) begin
						case (dat_lg)
							2'd2: sh <= {sh[27:0], sdl_s2};
							2'd1: sh <= {sh[29:0], sdl_s2[1:0]};
							default: sh <= {sh[30:0], sdl_s2[1]};
						endcase
					end
					if (fall) begin
						cnt <= cnt - 6'd1;
						if (cnt == 6'd1) begin
							state <= ST_PUSH;
						end
					end
				end
				ST_PUSH: begin
					next_fa <= pend_fa + WORD_STEP;
					pend_fa <= pend_fa + WORD_STEP;
					sess_open <= 1'b1;
					state <= ST_HOLD;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// data line drive; unused upper lines stay released
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sdl_out <= '0;
			o_sdl_oe_n <= '1;
		end else begin
			o_sdl_out <= '0;
			o_sdl_oe_n <= '1;
			if (state == ST_ADDR || (state == ST_DUMMY && drv != '0)) begin
				case ((state == ST_ADDR) ? addr_lg : dum_lg)
					2'd2: begin
						o_sdl_out <= sh[31:28];
						o_sdl_oe_n <= 4'h0;
					end
					2'd1: begin
						o_sdl_out <= {2'b00, sh[31:30]};
						o_sdl_oe_n <= 4'hc;
					end
					default: begin
						o_sdl_out <= {3'b000, sh[31]};
						o_sdl_oe_n <= 4'he;
					end
				endcase
			end
		end
	end

	// read accept gate, held off while the FIFO is full
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_ready <= 1'b0;
		end else begin
			o_rd_ready <= (state == ST_IDLE || state == ST_HOLD) && eff_en && !exit_pend
				&& fifo_in_rdy && !acc;
		end
	end

	qmfr_fifo #(
		.WIDTH(32),
		.DEPTH(DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_valid(push),
		.o_ready(fifo_in_rdy),
		.i_data(sh),
		.o_valid(o_rdata_valid),
		.i_ready(i_rdata_ready),
		.o_data(o_rdata)
	);

	// checks
	logic [4:0] gl;
	logic [5:0] fe;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gl <= '0;
			fe <= '0;
		end else begin
			gl <= (state == ST_GAP) ? gl + 5'd1 : '0;
			if (fall && cnt == 6'd1) begin
				fe <= '0;
			end else if (fall) begin
				fe <= fe + 6'd1;
			end
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_gap_length: assert property ($fell(state == ST_GAP) |-> gl == 5'(select_idle_gap) + 5'd1
		&& o_flash_select_n == 1'b0) else $error("select gap length wrong");
	a_addr_clocks: assert property (state == ST_ADDR && fall && cnt == 6'd1 |->
		fe + 6'd1 == addr_clks) else $error("address clock count wrong");
	a_dummy_clocks: assert property (state == ST_DUMMY && fall && cnt == 6'd1 |->
		fe == 6'(flash_map_read_config[F_DLEN +: 4])) else $error("dummy length wrong");
	a_upper_lanes: assert property (dat_lg != 2'd2 && addr_lg != 2'd2 && dum_lg != 2'd2
		&& $stable(flash_map_read_config) |=> o_sdl_oe_n[3:2] == 2'b11)
		else $error("upper lines driven");
	a_quad_addr: assert property ($past(state) == ST_ADDR && state == ST_ADDR
		&& addr_lg == 2'd2 |-> o_sdl_oe_n == 4'h0) else $error("quad address not driven");
	a_exit_ones: assert property ($past(state) == ST_ADDR && state == ST_ADDR && exiting
		|-> (o_sdl_out | o_sdl_oe_n) == 4'hf) else $error("exit address not all ones");
	a_exit_start: assert property ($fell(eff_en) |-> ##[1:3] (state == ST_GAP && exiting))
		else $error("exit sequence not started");
	a_slave_ignore: assert property (!controller_role |=> !o_rd_ready)
		else $error("read accepted in slave role");
	a_mode_lsb: assert property (state == ST_DUMMY && $past(state) == ST_ADDR && dum_lg == 2'd0
		|=> o_sdl_out[0] == mode_cur[0]) else $error("mode byte not LSB first");
	a_drive_stop: assert property (state == ST_DUMMY && drv == '0 |=> o_sdl_oe_n == 4'hf)
		else $error("dummy drive too long");
	a_push_room: assert property (push |-> fifo_in_rdy) else $error("push into full FIFO");

	c_seq_read: cover property (state == ST_HOLD && acc && sess_open && fa == next_fa);
	c_exit_done: cover property (state == ST_DUMMY && exiting ##1 state == ST_IDLE);
	c_quad_data: cover property (state == ST_DATA && dat_lg == 2'd2 ##[1:100] push);
	c_fifo_full: cover property (!fifo_in_rdy);
endmodule : qmfr_seq

//--- test/qmfr_flash_model.sv
// qmfr_flash_model: behavioural serial flash answering mapped reads.
// assumes the bench resolves the shared lines and hands in the frame layout.
module qmfr_flash_model (
	input wire logic i_sck,
	input wire logic i_sel_n,
	input wire logic [3:0] i_line,
	input wire logic [2:0] i_alanes,
	input wire logic [2:0] i_mlanes,
	input wire logic [2:0] i_dlanes,
	input wire logic [5:0] i_abits,
	input wire logic [4:0] i_dumclk,
	output logic [3:0] o_line,
	output logic o_drive
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] addr;
	logic [7:0] mode;
	int rises;
	int frames;
	initial begin
		o_line = 4'h0;
		o_drive = 1'b0;
		rises = 0;
		frames = 0;
	end
	always @(negedge i_sel_n) begin
		rises = 0;
		addr = 32'h0;
		frames++;
	end
	always @(posedge i_sel_n) begin
		o_drive <= 1'b0;
	end
	always @(posedge i_sck) begin
		int ac;
		ac = i_abits / i_alanes;
		if (rises < ac) begin
			for (int i = 3; i >= 0; i--) begin
				if (i < i_alanes) begin
					addr = {addr[30:0], i_line[i]};
				end
			end
		end else if (rises < ac + 8 / i_mlanes) begin
			// mode byte arrives lsb first, highest line first within a clock
			for (int i = 3; i >= 0; i--) begin
				if (i < i_mlanes) begin
					mode = {i_line[i], mode[7:1]};
				end
			end
		end
		rises++;
	end
	// data msb first; single mode answers on line 1
	always @(negedge i_sck) begin
		int k;
		int wc;
		logic [31:0] w;
		k = rises - i_abits / i_alanes - i_dumclk;
		wc = 32 / i_dlanes;
		if (!i_sel_n && k >= 0) begin
			w = (addr + 32'(4 * (k / wc))) ^ 32'h5a5a_c3c3;
			w = w << (i_dlanes * (k % wc));
			o_drive <= 1'b1;
			o_line <= i_dlanes == 3'h4 ? w[31:28] : i_dlanes == 3'h2 ? {2'h0, w[31:30]} :
				{2'h0, w[31], 1'b0};
		end
	end
endmodule : qmfr_flash_model

//--- test/qmfr_seq_bench.sv
// qmfr_seq_bench: self-checking bench for the mapped read sequencer.
// assumes qmfr_pkg and the flash model are compiled first.
module qmfr_seq_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import qmfr_pkg::*;
	typedef struct packed {
		logic [1:0] al;
		logic [1:0] ml;
		logic [1:0] dl;
		logic aw;
		logic [11:0] rm;
		logic [31:0] rel;
	} qmfr_row_s;
	localparam logic [7:0] KEEP = 8'h2d;
	localparam logic [7:0] EXIT = 8'hb4;
	localparam logic [31:0] SALT = 32'h5a5a_c3c3;
	localparam qmfr_row_s ROWS [5] = '{
		'{2'h0, 2'h0, 2'h0, 1'b0, 12'h001, 32'h0000_1230},
		'{2'h1, 2'h1, 2'h1, 1'b1, 12'h012, 32'h0004_5670},
		'{2'h2, 2'h2, 2'h2, 1'b0, 12'h123, 32'h0000_0ff0},
		'{2'h2, 2'h0, 2'h1, 1'b1, 12'hfff, 32'h0010_0000},
		'{2'h0, 2'h2, 2'h2, 1'b1, 12'h800, 32'h0000_0044}};
	logic clk, rst_n, avm_rd, avm_wr, rd_valid, rdata_ready, fl_drive, bad23, ok;
	logic [7:0] avm_addr;
	logic [31:0] avm_wd, rd_addr, rq, o_avm_readdata, o_rdata;
	logic o_avm_waitrequest, o_rd_ready, o_rdata_valid, o_flash_select_n, o_sck;
	logic [3:0] o_sdl_out, o_sdl_oe_n, sdl_in, fl_line, flt;
	logic [2:0] m_al, m_ml, m_dl;
	logic [5:0] m_ab;
	logic [4:0] m_dc;
	int error_cnt, checks_done, hi_run, last_gap, nt, f0;
	qmfr_seq #(.SCK_HALF(SCK_HALF_DEF), .DEPTH(FIFO_DEPTH)) dut_u (.i_clk(clk), .i_rst_n(rst_n),
		.i_avm_address(avm_addr), .i_avm_read(avm_rd), .i_avm_write(avm_wr),
		.i_avm_writedata(avm_wd), .i_avm_byteenable(4'hf), .o_avm_readdata(o_avm_readdata),
		.o_avm_waitrequest(o_avm_waitrequest), .i_rd_valid(rd_valid), .i_rd_addr(rd_addr),
		.o_rd_ready(o_rd_ready), .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata),
		.i_rdata_ready(rdata_ready), .o_flash_select_n(o_flash_select_n), .o_sck(o_sck),
		.o_sdl_out(o_sdl_out), .o_sdl_oe_n(o_sdl_oe_n), .i_sdl_in(sdl_in));
	qmfr_flash_model fl_u (.i_sck(o_sck), .i_sel_n(o_flash_select_n), .i_line(sdl_in),
		.i_alanes(m_al), .i_mlanes(m_ml), .i_dlanes(m_dl), .i_abits(m_ab), .i_dumclk(m_dc),
		.o_line(fl_line), .o_drive(fl_drive));
	// released lines show a pattern that moves every cycle
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			sdl_in[i] = !o_sdl_oe_n[i] ? o_sdl_out[i] : fl_drive ? fl_line[i] : flt[i];
		end
	end
	always @(posedge clk) begin
		flt <= ~flt;
		if (m_al != 3'h4 && m_ml != 3'h4 && m_dl != 3'h4 && o_sdl_oe_n[3:2] !== 2'b11) begin
			bad23 <= 1'b1;
		end
		if (o_flash_select_n === 1'b1) begin
			hi_run <= hi_run + 1;
		end else begin
			if (hi_run != 0) last_gap <= hi_run;
			hi_run <= 0;
		end
	end
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task avm(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avm_addr <= a;
		avm_wr <= w;
		avm_rd <= !w;
		avm_wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (o_avm_waitrequest !== 1'b0 && n < 50);
		check({31'h0, o_avm_waitrequest}, 32'h0);
		rq = o_avm_readdata;
		avm_wr <= 1'b0;
		avm_rd <= 1'b0;
		@(posedge clk);
	endtask : avm
	task wr(input logic [7:0] a, input logic [31:0] d);
		avm(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a);
		avm(1'b0, a, 32'h0);
	endtask : rd
	task cfg_w(input logic [1:0] al, ml, dl, input logic aw, en);
		logic [3:0] drv;
		m_al <= al == LANE_QUAD ? 3'h4 : al == LANE_DUAL ? 3'h2 : 3'h1;
		m_ml <= ml == LANE_QUAD ? 3'h4 : ml == LANE_DUAL ? 3'h2 : 3'h1;
		m_dl <= dl == LANE_QUAD ? 3'h4 : dl == LANE_DUAL ? 3'h2 : 3'h1;
		m_ab <= aw ? ADDR32 : ADDR24;
		drv = ml == LANE_QUAD ? 4'h1 : ml == LANE_DUAL ? 4'h3 : 4'h7;
		m_dc <= 5'(drv) + 5'h2;
		wr(OFS_CFG, {16'h0, drv, drv + 4'h1, dl, ml, al, aw, en});
	endtask : cfg_w
	task rd_take(input logic [31:0] rel, input int lim);
		int n;
		n = 0;
		rd_valid <= 1'b1;
		rd_addr <= rel;
		do begin
			@(posedge clk);
			n++;
		end while (o_rd_ready !== 1'b1 && n < lim);
		ok = o_rd_ready === 1'b1;
		rd_valid <= 1'b0;
		@(posedge clk);
	endtask : rd_take
	task pop_chk(input logic [31:0] exp);
		int n;
		n = 0;
		while (o_rdata_valid !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, o_rdata_valid}, 32'h1);
		check(o_rdata, exp);
		rdata_ready <= 1'b1;
		@(posedge clk);
		rdata_ready <= 1'b0;
		@(posedge clk);
	endtask : pop_chk
	task wait_exit(input int f);
		int n;
		n = 0;
		while (!(fl_u.frames == f + 1 && o_flash_select_n === 1'b1) && n < 6000) begin
			@(posedge clk);
			n++;
		end
		check(32'(fl_u.frames - f), 32'h1);
	endtask : wait_exit
	task run_row(input qmfr_row_s t);
		logic [31:0] msk;
		logic [31:0] fa;
		msk = t.aw ? 32'hffff_ffff : 32'h00ff_ffff;
		fa = ({t.rm, 20'h0} + t.rel) & msk;
		bad23 = 1'b0;
		wr(OFS_REMAP, {16'h0, t.rm, 4'h0});
		cfg_w(t.al, t.ml, t.dl, t.aw, 1'b1);
		rd_take(t.rel, 4000);
		check({31'h0, ok}, 32'h1);
		pop_chk(fa ^ SALT);
		check(fl_u.addr, fa);
		check({24'h0, fl_u.mode}, {24'h0, KEEP});
		check({31'h0, bad23}, 32'h0);
		f0 = fl_u.frames;
		cfg_w(t.al, t.ml, t.dl, t.aw, 1'b0);
		wait_exit(f0);
		check(fl_u.addr, msk);
		check({24'h0, fl_u.mode}, {24'h0, EXIT});
	endtask : run_row
	initial begin
		#2_000_000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		{rst_n, avm_rd, avm_wr, rd_valid, rdata_ready, bad23} = 6'h0;
		{avm_addr, avm_wd, rd_addr} = '0;
		{m_al, m_ml, m_dl, m_ab, m_dc} = {3'h1, 3'h1, 3'h1, ADDR24, 5'h2};
		{error_cnt, checks_done, hi_run, last_gap} = '0;
		flt = 4'h5;
		repeat (8) @(posedge clk);
		check({o_flash_select_n, o_sck, o_avm_waitrequest, o_rd_ready, o_rdata_valid}, 32'h14);
		check({28'h0, o_sdl_oe_n}, 32'hf);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(OFS_CFG);
		check(rq, {16'h0, CFG_RST});
		rd(OFS_MODE);
		check(rq, {16'h0, MODE_RST});
		wr(8'h20, 32'hffff);
		rd(8'h20);
		check(rq, 32'h0);
		wr(OFS_MODE, {16'h0, KEEP, EXIT});
		rd(OFS_MODE);
		check(rq, {16'h0, KEEP, EXIT});
		wr(OFS_GAP, 32'h5);
		cfg_w(LANE_SINGLE, LANE_SINGLE, LANE_SINGLE, 1'b0, 1'b1);
		rd(OFS_STAT);
		check({31'h0, rq[3]}, 32'h0);
		rd_take(32'h0, 200);
		check({31'h0, ok}, 32'h0);
		cfg_w(LANE_SINGLE, LANE_SINGLE, LANE_SINGLE, 1'b0, 1'b0);
		wr(OFS_CTRL, 32'h1);
		rd_take(32'h0, 200);
		check({31'h0, ok}, 32'h0);
		$display("registers and refusals done");
		for (int r = 0; r < 5; r++) begin
			run_row(ROWS[r]);
			$display("row %0d done", r);
		end
		wr(OFS_REMAP, 32'h0);
		cfg_w(LANE_QUAD, LANE_QUAD, LANE_QUAD, 1'b1, 1'b1);
		f0 = fl_u.frames;
		nt = 0;
		for (int k = 0; k < 9; k++) begin
			rd_take(32'h40 + 32'(4 * k), 2000);
			nt += int'(ok);
		end
		check(32'(nt), 32'(FIFO_DEPTH));
		check(32'(fl_u.frames - f0), 32'h1);
		for (int k = 0; k < 8; k++) begin
			pop_chk((32'h40 + 32'(4 * k)) ^ SALT);
		end
		rd_take(32'h200, 4000);
		pop_chk(32'h200 ^ SALT);
		check(32'(last_gap), 32'h6);
		f0 = fl_u.frames;
		cfg_w(LANE_QUAD, LANE_QUAD, LANE_QUAD, 1'b1, 1'b0);
		wait_exit(f0);
		$display("buffer and sequential reads done");
		// reset in the middle of a frame
		cfg_w(LANE_QUAD, LANE_QUAD, LANE_QUAD, 1'b1, 1'b1);
		rd_take(32'h80, 4000);
		repeat (20) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		check({o_flash_select_n, o_sck, o_avm_waitrequest, o_rd_ready, o_rdata_valid}, 32'h14);
		check({28'h0, o_sdl_oe_n}, 32'hf);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(OFS_CFG);
		check(rq, {16'h0, CFG_RST});
		$display("mid-frame reset done");
		report_and_stop();
	end
endmodule : qmfr_seq_bench
